// ### include/fps_regs.vh
/*
 * command codes, timing figures and bus widths for the flash program/verify host sequencer.
 * assumes a 100 MHz clock_i; included by bare name from the src files.
 */
`ifndef FPS_REGS_VH
`define FPS_REGS_VH

`define FPS_CMD_READ        8'h00
`define FPS_CMD_PGM_SETUP   8'h40
`define FPS_CMD_PGM_VERIFY  8'hc0
`define FPS_CMD_ERS_VERIFY  8'ha0
`define FPS_CMD_RESET       8'hff
`define FPS_DATA_ERASED     8'hff

`define FPS_ADDR_W          17
`define FPS_DATA_W          8

`define FPS_CLK_MHZ         100
`define FPS_PGM_PULSE_US    10
`define FPS_RECOVERY_US     6
`define FPS_PGM_PULSE_CYC   (`FPS_PGM_PULSE_US * `FPS_CLK_MHZ)
`define FPS_RECOVERY_CYC    (`FPS_RECOVERY_US * `FPS_CLK_MHZ)
`define FPS_MAX_PULSES      5'h19
`define FPS_CNT_W           11

`define FPS_BUS_SETUP_CYC   11'h003
`define FPS_BUS_STROBE_CYC  11'h006
`define FPS_BUS_HOLD_CYC    11'h003

`endif

// ### src/fps_bus_cycle.v
/*
 * one asynchronous write or read cycle on the flash bus.
 * assumes the flash latches address on falling strobe and data on rising strobe.
 */
`timescale 1ns/10ps
`default_nettype none
`include "fps_regs.vh"
module fps_bus_cycle
(
    // system
    input  wire                     clock_i,
    input  wire                     sys_rst_i,
    // request
    input  wire                     start_i,
    input  wire                     read_i,
    input  wire [`FPS_ADDR_W-1:0]   addr_i,
    input  wire [`FPS_DATA_W-1:0]   data_i,
    output reg                      done_o,
    output reg  [`FPS_DATA_W-1:0]   rdata_o,
    // flash pins
    output reg  [`FPS_ADDR_W-1:0]   fl_addr_o,
    output reg  [`FPS_DATA_W-1:0]   fl_dq_o,
    output reg                      fl_dq_oe_o,
    input  wire [`FPS_DATA_W-1:0]   fl_dq_i,
    output reg                      fl_we_n_o,
    output reg                      fl_oe_n_o,
    output reg                      fl_ce_n_o,
    // rising write strobe seen
    output reg                      we_rise_o
);
    localparam ST_IDLE  = 2'h0;
    localparam ST_SETUP = 2'h1;
    localparam ST_STRB  = 2'h2;
    localparam ST_HOLD  = 2'h3;

    reg [1:0]             state_ff;
    reg [`FPS_CNT_W-1:0]  cnt_ff;
    reg                   rd_ff;

    always @(posedge clock_i)
    begin
        done_o    <= 1'b0;
        we_rise_o <= 1'b0;
        if (sys_rst_i)
        begin
            state_ff   <= ST_IDLE;
            cnt_ff     <= {`FPS_CNT_W{1'b0}};
            rd_ff      <= 1'b0;
            rdata_o    <= {`FPS_DATA_W{1'b0}};
            fl_addr_o  <= {`FPS_ADDR_W{1'b0}};
            fl_dq_o    <= {`FPS_DATA_W{1'b0}};
            fl_dq_oe_o <= 1'b0;
            fl_we_n_o  <= 1'b1;
            fl_oe_n_o  <= 1'b1;
            fl_ce_n_o  <= 1'b1;
        end
        else
        begin
            case (state_ff)
                ST_IDLE:
                    if (start_i)
                    begin
                        rd_ff      <= read_i;
                        fl_addr_o  <= addr_i;
                        fl_dq_o    <= data_i;
                        fl_dq_oe_o <= ~read_i;
                        fl_ce_n_o  <= 1'b0;
                        cnt_ff     <= `FPS_BUS_SETUP_CYC;
                        state_ff   <= ST_SETUP;
                    end
                ST_SETUP:
                    if (cnt_ff == {`FPS_CNT_W{1'b0}})
                    begin
                        fl_we_n_o <= rd_ff;
                        fl_oe_n_o <= ~rd_ff;
                        cnt_ff    <= `FPS_BUS_STROBE_CYC;
                        state_ff  <= ST_STRB;
                    end
                    else
                        cnt_ff <= cnt_ff - 1'b1;
                ST_STRB:
                    if (cnt_ff == {`FPS_CNT_W{1'b0}})
                    begin
                        if (rd_ff)
                            rdata_o <= fl_dq_i;
                        we_rise_o <= ~rd_ff;
                        fl_we_n_o <= 1'b1;
                        fl_oe_n_o <= 1'b1;
                        cnt_ff    <= `FPS_BUS_HOLD_CYC;
                        state_ff  <= ST_HOLD;
                    end
                    else
                        cnt_ff <= cnt_ff - 1'b1;
                ST_HOLD:
                    if (cnt_ff == {`FPS_CNT_W{1'b0}})
                    begin
                        fl_dq_oe_o <= 1'b0;
                        fl_ce_n_o  <= 1'b1;
                        done_o     <= 1'b1;
                        state_ff   <= ST_IDLE;
                    end
                    else
                        cnt_ff <= cnt_ff - 1'b1;
                default:
                    state_ff <= ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ### src/fps_host.v
/*
 * host sequencer: programs and verifies one byte, erase-verifies one byte, masks, resets.
 * assumes the caller ramps the high programming supply and reports it on vpp_ok_i.
 */
`timescale 1ns/10ps
`default_nettype none
`include "fps_regs.vh"
// Operation
// - host keeps target byte, compares, reprograms on mismatch, finishes on match.
// - at most 25 program pulses per byte, then report failure.
// - host times 10 us from rising strobe of program write.
// - host writes C0h after pulse delay to end it and stage verify.
// - host waits 6 us after any verify command before reading.
// - host writes reset after each program sequence.
// - host ends pulse on delay expiry or before serving an interrupt.
// - erase pulse 10 ms with erase-verify after each; not sequenced here.
// - host masks an erased device by writing read command 00h.
// - after setup, reset must be written twice to abort.
// - host always sends reset twice in a row.
// - erase-verify A0h carries the byte address and stages it.
module fps_host
(
    // system
    input  wire                     clock_i,
    input  wire                     sys_rst_i,
    // user request
    input  wire                     prog_req_i,
    input  wire                     ev_req_i,
    input  wire                     mask_req_i,
    input  wire                     reset_req_i,
    input  wire                     irq_pending_i,
    input  wire                     vpp_ok_i,
    input  wire [`FPS_ADDR_W-1:0]   addr_i,
    input  wire [`FPS_DATA_W-1:0]   data_i,
    // user answer
    output reg                      busy_o,
    output reg                      done_o,
    output reg                      pass_o,
    output reg  [`FPS_DATA_W-1:0]   rdata_o,
    output reg  [4:0]               pulses_o,
    // flash pins
    output wire [`FPS_ADDR_W-1:0]   fl_addr_o,
    output wire [`FPS_DATA_W-1:0]   fl_dq_o,
    output wire                     fl_dq_oe_o,
    input  wire [`FPS_DATA_W-1:0]   fl_dq_i,
    output wire                     fl_we_n_o,
    output wire                     fl_oe_n_o,
    output wire                     fl_ce_n_o
);
    localparam ST_IDLE   = 4'h0;
    localparam ST_SETUP  = 4'h1;
    localparam ST_PROG   = 4'h2;
    localparam ST_PULSE  = 4'h3;
    localparam ST_VCMD   = 4'h4;
    localparam ST_RECOV  = 4'h5;
    localparam ST_READ   = 4'h6;
    localparam ST_RST1   = 4'h7;
    localparam ST_RST2   = 4'h8;
    localparam ST_FINISH = 4'h9;
    localparam ST_MASK   = 4'ha;
    // timer loads, cut to counter width below
    localparam [31:0] PULSE_LOAD = `FPS_PGM_PULSE_CYC - 1;
    localparam [31:0] RECOV_LOAD = `FPS_RECOVERY_CYC - 1;

    reg [3:0]             state_ff;
    reg                   ers_ff;
    reg                   ok_ff;
    reg [`FPS_ADDR_W-1:0] addr_ff;
    reg [`FPS_DATA_W-1:0] want_ff;
    reg [`FPS_CNT_W-1:0]  tmr_ff;
    reg [2:0]             irq_sync_ff;
    reg [2:0]             vpp_sync_ff;
    reg                   irq_ff;
    reg                   vpp_ff;

    // bus cycle request
    reg                   bc_start_ff;
    reg                   bc_read_ff;
    reg [`FPS_DATA_W-1:0] bc_data_ff;
    wire                  bc_done;
    wire                  bc_rise;
    wire [`FPS_DATA_W-1:0] bc_rdata;

    fps_bus_cycle u_bus
    (
        .clock_i    (clock_i),
        .sys_rst_i  (sys_rst_i),
        .start_i    (bc_start_ff),
        .read_i     (bc_read_ff),
        .addr_i     (addr_ff),
        .data_i     (bc_data_ff),
        .done_o     (bc_done),
        .rdata_o    (bc_rdata),
        .fl_addr_o  (fl_addr_o),
        .fl_dq_o    (fl_dq_o),
        .fl_dq_oe_o (fl_dq_oe_o),
        .fl_dq_i    (fl_dq_i),
        .fl_we_n_o  (fl_we_n_o),
        .fl_oe_n_o  (fl_oe_n_o),
        .fl_ce_n_o  (fl_ce_n_o),
        .we_rise_o  (bc_rise)
    );

    // pin-level inputs, agreed on stages two and three
    always @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            irq_sync_ff <= 3'h0;
            vpp_sync_ff <= 3'h0;
            irq_ff      <= 1'b0;
            vpp_ff      <= 1'b0;
        end
        else
        begin
            irq_sync_ff <= {irq_sync_ff[1:0], irq_pending_i};
            vpp_sync_ff <= {vpp_sync_ff[1:0], vpp_ok_i};
            if (irq_sync_ff[1] == irq_sync_ff[2])
                irq_ff <= irq_sync_ff[2];
            if (vpp_sync_ff[1] == vpp_sync_ff[2])
                vpp_ff <= vpp_sync_ff[2];
        end
    end

    always @(posedge clock_i)
    begin
        bc_start_ff <= 1'b0;
        done_o      <= 1'b0;
        if (sys_rst_i)
        begin
            state_ff   <= ST_IDLE;
            ers_ff     <= 1'b0;
            ok_ff      <= 1'b0;
            addr_ff    <= {`FPS_ADDR_W{1'b0}};
            want_ff    <= {`FPS_DATA_W{1'b0}};
            tmr_ff     <= {`FPS_CNT_W{1'b0}};
            bc_read_ff <= 1'b0;
            bc_data_ff <= {`FPS_DATA_W{1'b0}};
            busy_o     <= 1'b0;
            pass_o     <= 1'b0;
            rdata_o    <= {`FPS_DATA_W{1'b0}};
            pulses_o   <= 5'h0;
        end
        else
        begin
            case (state_ff)
                ST_IDLE:
                begin
                    busy_o     <= 1'b0;
                    bc_read_ff <= 1'b0;
                    addr_ff    <= addr_i;
                    want_ff    <= data_i;
                    if (reset_req_i)
                    begin
                        busy_o   <= 1'b1;
                        ok_ff    <= 1'b1;
                        state_ff <= ST_RST1;
                    end
                    else if (mask_req_i)
                    begin
                        busy_o      <= 1'b1;
                        bc_data_ff  <= `FPS_CMD_READ;
                        bc_start_ff <= 1'b1;
                        state_ff    <= ST_MASK;
                    end
                    else if ((prog_req_i || ev_req_i) && !vpp_ff)
                    begin
                        pass_o <= 1'b0;
                        done_o <= 1'b1;
                    end
                    else if (prog_req_i)
                    begin
                        busy_o      <= 1'b1;
                        ers_ff      <= 1'b0;
                        pulses_o    <= 5'h0;
                        bc_data_ff  <= `FPS_CMD_PGM_SETUP;
                        bc_start_ff <= 1'b1;
                        state_ff    <= ST_SETUP;
                    end
                    else if (ev_req_i)
                    begin
                        busy_o      <= 1'b1;
                        ers_ff      <= 1'b1;
                        want_ff     <= `FPS_DATA_ERASED;
                        bc_data_ff  <= `FPS_CMD_ERS_VERIFY;
                        bc_start_ff <= 1'b1;
                        state_ff    <= ST_VCMD;
                    end
                end
                ST_SETUP:
                    if (bc_done)
                    begin
                        bc_data_ff  <= want_ff;
                        bc_start_ff <= 1'b1;
                        pulses_o    <= pulses_o + 5'h1;
                        state_ff    <= ST_PROG;
                    end
                ST_PROG:
                    if (bc_rise)
                    begin
                        tmr_ff   <= PULSE_LOAD[`FPS_CNT_W-1:0];
                        state_ff <= ST_PULSE;
                    end
                ST_PULSE:
                    if (!fl_ce_n_o || tmr_ff != {`FPS_CNT_W{1'b0}})
                    begin
                        if (tmr_ff != {`FPS_CNT_W{1'b0}})
                            tmr_ff <= tmr_ff - 1'b1;
                        // early end before serving interrupt
                        if (irq_ff && !bc_start_ff && tmr_ff != {`FPS_CNT_W{1'b0}})
                        begin
                            tmr_ff <= {`FPS_CNT_W{1'b0}};
                        end
                    end
                    else
                    begin
                        bc_data_ff  <= `FPS_CMD_PGM_VERIFY;
                        bc_start_ff <= 1'b1;
                        state_ff    <= ST_VCMD;
                    end
                ST_VCMD:
                    if (bc_done)
                    begin
                        tmr_ff   <= RECOV_LOAD[`FPS_CNT_W-1:0];
                        state_ff <= ST_RECOV;
                    end
                ST_RECOV:
                    if (tmr_ff == {`FPS_CNT_W{1'b0}})
                    begin
                        bc_read_ff  <= 1'b1;
                        bc_start_ff <= 1'b1;
                        state_ff    <= ST_READ;
                    end
                    else
                        tmr_ff <= tmr_ff - 1'b1;
                ST_READ:
                    if (bc_done)
                    begin
                        bc_read_ff <= 1'b0;
                        rdata_o    <= bc_rdata;
                        if (bc_rdata == want_ff || ers_ff
                            || pulses_o == `FPS_MAX_PULSES)
                        begin
                            ok_ff    <= (bc_rdata == want_ff);
                            state_ff <= ST_RST1;
                        end
                        else
                        begin
                            bc_data_ff  <= `FPS_CMD_PGM_SETUP;
                            bc_start_ff <= 1'b1;
                            state_ff    <= ST_SETUP;
                        end
                    end
                ST_RST1:
                begin
                    bc_data_ff  <= `FPS_CMD_RESET;
                    bc_start_ff <= 1'b1;
                    state_ff    <= ST_RST2;
                end
                ST_RST2:
                    if (bc_done)
                    begin
                        bc_start_ff <= 1'b1;
                        state_ff    <= ST_FINISH;
                    end
                ST_FINISH, ST_MASK:
                    if (bc_done)
                    begin
                        pass_o   <= (state_ff == ST_MASK) ? 1'b1 : ok_ff;
                        done_o   <= 1'b1;
                        busy_o   <= 1'b0;
                        state_ff <= ST_IDLE;
                    end
                default:
                    state_ff <= ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ### bench/fps_host_sva.sv
/* checker: order and timing of the flash pin traffic of fps_host
   assumes 100 MHz clock_i; bound to every fps_host instance */
`timescale 1ns/10ps
`default_nettype none
`include "fps_regs.vh"
module fps_host_sva
(
    // system
    input wire logic                   clock_i,
    input wire logic                   sys_rst_i,
    // user side
    input wire logic                   irq_pending_i,
    input wire logic                   vpp_ok_i,
    input wire logic [4:0]             pulses_o,
    // flash pins
    input wire logic [`FPS_ADDR_W-1:0] fl_addr_o,
    input wire logic [7:0]             fl_dq_o,
    input wire logic                   fl_dq_oe_o,
    input wire logic                   fl_we_n_o,
    input wire logic                   fl_oe_n_o,
    input wire logic                   fl_ce_n_o
);
    logic        we_q_ff;
    logic [10:0] since_ff;
    // {setup armed, pulse running, verify staged, single reset seen}
    logic [3:0]  hist_ff;
    logic        irq_ff;
    wire         rise_w = fl_we_n_o & ~we_q_ff;

    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    always_ff @(posedge clock_i)
    begin
        we_q_ff <= fl_we_n_o;
        if (sys_rst_i)
        begin
            since_ff <= 11'h000;
            hist_ff  <= 4'h0;
            irq_ff   <= 1'b0;
        end
        else if (rise_w)
        begin
            since_ff <= 11'h000;
            hist_ff  <= {~hist_ff[3] & (fl_dq_o == 8'h40), hist_ff[3],
                         ~hist_ff[3] & (fl_dq_o == 8'hc0 | fl_dq_o == 8'ha0),
                         ~hist_ff[3] & (fl_dq_o == 8'hff)};
            irq_ff   <= 1'b0;
        end
        else
        begin
            since_ff <= since_ff + {10'h000, ~&since_ff};
            irq_ff   <= irq_ff | irq_pending_i;
        end
    end

    sequence wr_s(logic [7:0] v);
        $fell(fl_we_n_o) && fl_dq_o == v;
    endsequence
    sequence pulse_end_s;
        $fell(fl_we_n_o) && hist_ff[2];
    endsequence

    chk_strobe_chip: assert property ((!fl_we_n_o || !fl_oe_n_o) |-> !fl_ce_n_o)
        else $error("strobe without chip enable");
    chk_dq_owner: assert property (fl_dq_oe_o ? fl_oe_n_o : fl_we_n_o)
        else $error("data bus owner clash");
    chk_latch_stable: assert property (!fl_we_n_o && !$past(fl_we_n_o) |->
        $stable(fl_addr_o) && $stable(fl_dq_o)) else $error("write moved under strobe");
    chk_pulse_len: assert property (pulse_end_s |-> fl_dq_o == 8'hc0 &&
        (since_ff >= 11'h3e8 || irq_ff) && since_ff <= 11'h406) else $error("bad pulse end");
    chk_verify_wait: assert property ($fell(fl_oe_n_o) && hist_ff[1] |->
        since_ff >= 11'h258) else $error("verify read too early");
    chk_reset_pair: assert property (rise_w && fl_dq_o == 8'hff &&
        hist_ff[3:0] == 4'h0 |-> ##[1:40] wr_s(8'hff)) else $error("single reset write");
    chk_pulse_cap: assert property (pulses_o <= 5'h19)
        else $error("pulse count above limit");
    chk_vpp_gate: assert property ((!vpp_ok_i) [*8] |-> not wr_s(8'h40))
        else $error("program setup without supply");
endmodule

bind fps_host fps_host_sva u_sva
(
    .clock_i      (clock_i),
    .sys_rst_i    (sys_rst_i),
    .irq_pending_i(irq_pending_i),
    .vpp_ok_i     (vpp_ok_i),
    .pulses_o     (pulses_o),
    .fl_addr_o    (fl_addr_o),
    .fl_dq_o      (fl_dq_o),
    .fl_dq_oe_o   (fl_dq_oe_o),
    .fl_we_n_o    (fl_we_n_o),
    .fl_oe_n_o    (fl_oe_n_o),
    .fl_ce_n_o    (fl_ce_n_o)
);
`default_nettype wire

// ### bench/fps_flash_model.sv
/* flash device model: command decoder, byte array, margin window
   assumes the bench resolves the split data bus */
`timescale 1ns/10ps
`default_nettype none
`include "fps_regs.vh"
module fps_flash_model
(
    // flash pins
    input  wire logic [`FPS_ADDR_W-1:0] addr_i,
    input  wire logic [7:0]             dq_i,
    input  wire logic                   we_n_i,
    input  wire logic                   oe_n_i,
    input  wire logic                   ce_n_i,
    input  wire logic                   vpp_i,
    // observation
    output logic [7:0]                  dq_o,
    output logic [2:0]                  mode_o,
    output logic [7:0]                  cmd_o,
    output logic [7:0]                  odd_o
);
    logic [7:0]             mem [0:131071];
    logic [`FPS_ADDR_W-1:0] lat_a;
    logic [4:0]             npulse;
    realtime                t_we;
    realtime                t_vfy;

    initial
    begin
        for (int i = 0; i < 131072; i++)
            mem[i] = 8'hff;
        mode_o = 3'h0;
        cmd_o = 8'h00;
        odd_o = 8'h00;
        npulse = 5'h00;
        dq_o = 8'h5a;
        t_vfy = 0;
    end

    always @(negedge we_n_i)
        if (!ce_n_i)
            lat_a = addr_i;
    always @(posedge we_n_i)
    begin
        if (!ce_n_i && mode_o == 3'h1)
        begin
            // write after setup is program data, whatever its value
            if (vpp_i)
                mem[lat_a] = mem[lat_a] & dq_i;
            npulse = npulse + 5'h01;
            odd_o = odd_o + {7'h00, npulse > 5'h19};
            t_we = $realtime;
            mode_o = 3'h2;
        end
        else if (!ce_n_i)
        begin
            odd_o = odd_o + {7'h00, mode_o == 3'h2 && $realtime - t_we < 10000.0};
            cmd_o = dq_i;
            t_vfy = $realtime;
            npulse = (dq_i == 8'h40 || dq_i == 8'hc0) ? npulse : 5'h00;
            case (dq_i)
                8'h40: mode_o = 3'h1;
                8'hc0, 8'ha0: mode_o = 3'h3;
                default: mode_o = 3'h0;
            endcase
        end
    end

    // reads inside the recovery window return false data
    always @(negedge oe_n_i)
    begin
        if (mode_o == 3'h3 && $realtime - t_vfy < 6000.0)
            odd_o = odd_o + 8'h01;
        if (mode_o == 3'h3)
            dq_o = ($realtime - t_vfy < 6000.0) ? ~mem[lat_a] : mem[lat_a];
        else
            dq_o = mem[addr_i];
    end
    // released bus shows the inverse of the last value
    always @(posedge oe_n_i)
        dq_o = ~dq_o;
endmodule
`default_nettype wire

// ### bench/fps_host_tb_top.sv
/* self-checking bench of fps_host against the flash model
   assumes fps_regs.vh on the include path */
`timescale 1ns/10ps
`default_nettype none
`include "fps_regs.vh"
module fps_host_tb_top;
    logic        clock_i, sys_rst_i, vpp_ok_i, irq_pending_i;
    logic        prog_req_i, ev_req_i, mask_req_i, reset_req_i;
    logic [16:0] addr_i;
    logic [7:0]  data_i;
    wire         busy_o, done_o, pass_o, fl_dq_oe_o, fl_we_n_o, fl_oe_n_o, fl_ce_n_o;
    wire [7:0]   rdata_o, fl_dq_o, mdl_dq, cmd, odd;
    wire [4:0]   pulses_o;
    wire [16:0]  fl_addr_o;
    wire [2:0]   mode;
    wire [7:0]   dq_w = fl_dq_oe_o ? fl_dq_o : mdl_dq;
    logic [13:0] exp_q[$];
    logic [13:0] msk_q[$];
    logic [31:0] seed;
    logic [16:0] a [4];
    logic [7:0]  d [4];
    int          mismatches, n_tests, cycles;

    fps_host dut
    (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .prog_req_i(prog_req_i), .ev_req_i(ev_req_i), .mask_req_i(mask_req_i),
        .reset_req_i(reset_req_i), .irq_pending_i(irq_pending_i), .vpp_ok_i(vpp_ok_i),
        .addr_i(addr_i), .data_i(data_i), .busy_o(busy_o), .done_o(done_o),
        .pass_o(pass_o), .rdata_o(rdata_o), .pulses_o(pulses_o),
        .fl_addr_o(fl_addr_o), .fl_dq_o(fl_dq_o), .fl_dq_oe_o(fl_dq_oe_o),
        .fl_dq_i(dq_w), .fl_we_n_o(fl_we_n_o), .fl_oe_n_o(fl_oe_n_o), .fl_ce_n_o(fl_ce_n_o)
    );
    fps_flash_model mdl
    (
        .addr_i(fl_addr_o), .dq_i(dq_w), .we_n_i(fl_we_n_o), .oe_n_i(fl_oe_n_o),
        .ce_n_i(fl_ce_n_o), .vpp_i(vpp_ok_i), .dq_o(mdl_dq), .mode_o(mode),
        .cmd_o(cmd), .odd_o(odd)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input logic [13:0] seen, input logic [13:0] want);
        n_tests++;
        if (seen !== want)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h want %h", $time, seen, want);
        end
    endtask

    task automatic give_verdict();
        if (mismatches == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // k = {reset, mask, erase verify, program}; note {pass, pulses, rdata} under m
    task automatic run(input logic [3:0] k, input logic [16:0] ad, input logic [7:0] dt,
                       input logic [13:0] e, input logic [13:0] m);
        @(posedge clock_i);
        #1;
        {reset_req_i, mask_req_i, ev_req_i, prog_req_i} = k;
        addr_i = ad;
        data_i = dt;
        exp_q.push_back(e);
        msk_q.push_back(m);
        @(posedge clock_i);
        #1;
        {reset_req_i, mask_req_i, ev_req_i, prog_req_i} = 4'h0;
        check({13'h0000, busy_o}, {13'h0000, k[3] | k[2] | vpp_ok_i});
        @(posedge clock_i iff done_o === 1'b1);
    endtask

    initial
    begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    always @(posedge clock_i)
        if (done_o === 1'b1)
        begin
            check({pass_o, pulses_o, rdata_o} & msk_q[0], exp_q[0]);
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end

    always @(posedge clock_i)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            mismatches++;
            give_verdict();
        end
    end

    initial
    begin
        {prog_req_i, ev_req_i, mask_req_i, reset_req_i, irq_pending_i} = 5'h00;
        vpp_ok_i = 1'b1;
        addr_i = 17'h00000;
        data_i = 8'h00;
        seed = 32'h63e5;
        sys_rst_i = 1'b1;
        repeat (3) @(posedge clock_i);
        #1;
        sys_rst_i = 1'b0;
        check({odd[2:0], mode, cmd}, 14'h0000);
        repeat (4) @(posedge clock_i);
        for (int i = 0; i < 4; i++)
        begin
            seed = lfsr(seed);
            a[i] = seed[16:0];
            d[i] = (i == 3) ? 8'hff : seed[7:0] & 8'hfe;
            run(4'h1, a[i], d[i], {1'b1, 5'h01, d[i]}, 14'h3fff);
            check({odd[2:0], mode, cmd}, 14'h00ff);
            check({6'h00, mdl.mem[a[i]]}, {6'h00, d[i]});
        end
        // second value not a subset of the first: verify never matches
        run(4'h1, a[0], ~d[0], {1'b0, 5'h19, 8'h00}, 14'h3fff);
        check({odd[2:0], mode, cmd}, 14'h00ff);
        run(4'h2, ~a[0], 8'h00, {1'b1, 5'h00, 8'hff}, 14'h20ff);
        run(4'h2, a[0], 8'h00, {1'b0, 5'h00, 8'h00}, 14'h20ff);
        check({odd[2:0], mode, cmd}, 14'h00ff);
        run(4'h4, a[1], 8'h00, 14'h2000, 14'h2000);
        check({odd[2:0], mode, cmd}, 14'h0000);
        run(4'h8, a[1], 8'h00, 14'h2000, 14'h2000);
        check({odd[2:0], mode, cmd}, 14'h00ff);
        #1;
        vpp_ok_i = 1'b0;
        repeat (8) @(posedge clock_i);
        run(4'h1, ~a[1], 8'h00, 14'h0000, 14'h2000);
        check({6'h00, mdl.mem[~a[1]]}, 14'h00ff);
        #1;
        vpp_ok_i = 1'b1;
        repeat (8) @(posedge clock_i);
        fork
            run(4'h1, ~a[2], d[2], {1'b1, 5'h01, d[2]}, 14'h3fff);
            begin
                repeat (300) @(posedge clock_i);
                #1;
                irq_pending_i = 1'b1;
                repeat (20) @(posedge clock_i);
                #1;
                irq_pending_i = 1'b0;
            end
        join
        check({odd[2:0], mode, cmd}, 14'h08ff);
        give_verdict();
    end
endmodule
`default_nettype wire
